// ===== core/uabd_top.sv
// auto-baud detect unit with avalon register slave
module uabd_top (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic rx_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic irq_o,
    output logic receiver_idle_o,
    output logic bit_tick_o
);
    typedef struct packed {
        logic rx_s1;
        logic rx_s2;
        logic rx_d;
        uabd_pkg::uabd_state_t st;
        logic abd_en;
        logic wake_en;
        logic wide;
        logic hs;
        logic [15:0] div;
        logic [2:0] rises;
        logic [2:0] status;
        logic [2:0] mask;
        logic [7:0] rxdata;
        logic [31:0] rdata;
        logic ack;
        logic waitq;
        logic irq;
        logic idle;
        logic btick;
    } uabd_top_t;
    uabd_top_t r, next_r;
    uabd_tick_if tk();
    logic bit_tick;
    logic rise;
    logic fall;
    logic req;
    logic wr;
    logic rd;
    logic [2:0] ev;

    uabd_clkgen u_clkgen (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .tk(tk)
    );

    uabd_bitgen u_bitgen (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .run_i(r.st == uabd_pkg::UABD_IDLE),
        .divisor_i(r.div),
        .base_tick_i(tk.base_tick),
        .bit_tick_o(bit_tick)
    );

    assign tk.wide = r.wide;
    assign tk.high_speed = r.hs;
    assign tk.abd_sync = (r.st == uabd_pkg::UABD_WAIT_RISE) && rise;

    always_comb
    begin
        next_r = r;
        rise = r.rx_s2 && !r.rx_d;
        fall = !r.rx_s2 && r.rx_d;
        req = (avs_read_i || avs_write_i) && !r.ack;
        wr = req && avs_write_i;
        rd = req && avs_read_i;
        ev = 3'h0;
        next_r.rx_s1 = rx_i;
        next_r.rx_s2 = r.rx_s1;
        next_r.rx_d = r.rx_s2;
        next_r.ack = req;
        // registered waitrequest: high when idle, low in the answer cycle
        next_r.waitq = !req;
        next_r.btick = 1'b0;
        // register writes
        if (wr && avs_byteenable_i[0])
        begin
            case (avs_address_i)
                uabd_pkg::ADDR_CTRL:
                begin
                    next_r.abd_en = avs_writedata_i[uabd_pkg::CTRL_ABD_BIT];
                    next_r.wake_en = avs_writedata_i[uabd_pkg::CTRL_WAKE_BIT];
                    next_r.wide = avs_writedata_i[uabd_pkg::CTRL_WIDE_BIT];
                    next_r.hs = avs_writedata_i[uabd_pkg::CTRL_HS_BIT];
                end
                uabd_pkg::ADDR_DIV_LO: next_r.div[7:0] = avs_writedata_i[7:0];
                uabd_pkg::ADDR_DIV_HI: next_r.div[15:8] = avs_writedata_i[7:0];
                uabd_pkg::ADDR_STATUS:
                    next_r.status = r.status & ~avs_writedata_i[2:0];
                uabd_pkg::ADDR_MASK: next_r.mask = avs_writedata_i[2:0];
                default: next_r.mask = r.mask;
            endcase
        end
        if (rd && avs_address_i == uabd_pkg::ADDR_RXDATA)
            next_r.status[uabd_pkg::ST_RX_BIT] = 1'b0;
        // detection sequencer
        case (r.st)
            uabd_pkg::UABD_IDLE:
            begin
                next_r.btick = bit_tick;
                if (next_r.wake_en)
                    next_r.st = uabd_pkg::UABD_WAKE_LOW;
                else if (next_r.abd_en)
                    next_r.st = uabd_pkg::UABD_WAIT_START;
            end
            uabd_pkg::UABD_WAKE_LOW:
            begin
                if (!r.wake_en)
                    next_r.st = uabd_pkg::UABD_IDLE;
                else if (fall)
                begin
                    ev[uabd_pkg::ST_WAKE_BIT] = 1'b1;
                    ev[uabd_pkg::ST_RX_BIT] = 1'b1;
                end
                else if (rise)
                begin
                    next_r.wake_en = 1'b0;
                    next_r.st = r.abd_en ? uabd_pkg::UABD_WAIT_START
                                         : uabd_pkg::UABD_IDLE;
                end
            end
            uabd_pkg::UABD_WAIT_START:
            begin
                if (!r.abd_en)
                    next_r.st = uabd_pkg::UABD_IDLE;
                else if (fall)
                    next_r.st = uabd_pkg::UABD_WAIT_RISE;
            end
            uabd_pkg::UABD_WAIT_RISE:
            begin
                if (!r.abd_en)
                    next_r.st = uabd_pkg::UABD_IDLE;
                else if (rise)
                begin
                    next_r.div = uabd_pkg::ABD_COUNT_START;
                    next_r.rises = 3'h1;
                    next_r.st = uabd_pkg::UABD_MEASURE;
                end
            end
            uabd_pkg::UABD_MEASURE:
            begin
                if (tk.abd_tick)
                    next_r.div = r.div + 16'h0001;
                if (!r.abd_en)
                    next_r.st = uabd_pkg::UABD_IDLE;
                else if (rise)
                begin
                    next_r.rises = r.rises + 3'h1;
                    if (r.rises + 3'h1 == uabd_pkg::ABD_RISE_COUNT)
                    begin
                        next_r.abd_en = 1'b0;
                        next_r.st = uabd_pkg::UABD_IDLE;
                        ev[uabd_pkg::ST_RX_BIT] = 1'b1;
                        ev[uabd_pkg::ST_DONE_BIT] = 1'b1;
                    end
                end
            end
            default: next_r.st = uabd_pkg::UABD_IDLE;
        endcase
        // set wins over clear
        next_r.status = next_r.status | ev;
        next_r.idle = (next_r.st != uabd_pkg::UABD_IDLE);
        next_r.irq = |(next_r.status & next_r.mask);
        // read data
        next_r.rdata = uabd_pkg::UNMAPPED_READ;
        if (rd)
        begin
            case (avs_address_i)
                uabd_pkg::ADDR_CTRL:
                    next_r.rdata = {28'h0000000, r.hs, r.wide,
                        r.wake_en, r.abd_en};
                uabd_pkg::ADDR_DIV_LO: next_r.rdata = {24'h000000, r.div[7:0]};
                uabd_pkg::ADDR_DIV_HI:
                    next_r.rdata = {24'h000000, r.div[15:8]};
                uabd_pkg::ADDR_RXDATA: next_r.rdata = {24'h000000, r.rxdata};
                uabd_pkg::ADDR_STATUS: next_r.rdata = {29'h0, r.status};
                uabd_pkg::ADDR_MASK: next_r.rdata = {29'h0, r.mask};
                default: next_r.rdata = uabd_pkg::UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            r <= '0;
            r.rx_s1 <= 1'b1;
            r.rx_s2 <= 1'b1;
            r.rx_d <= 1'b1;
            r.waitq <= 1'b1;
            r.div <= uabd_pkg::DIV_RESET;
        end
        else
            r <= next_r;
    end

    assign avs_readdata_o = r.rdata;
    assign avs_waitrequest_o = r.waitq;
    assign irq_o = r.irq;
    assign receiver_idle_o = r.idle;
    assign bit_tick_o = r.btick;
endmodule

// ===== inc/uabd_pkg.sv
// constants, register map and types for the auto-baud detect block
package uabd_pkg;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_DIV_LO = 4'h1;
    localparam logic [3:0] ADDR_DIV_HI = 4'h2;
    localparam logic [3:0] ADDR_RXDATA = 4'h3;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_MASK = 4'h5;
    localparam int CTRL_ABD_BIT = 0;
    localparam int CTRL_WAKE_BIT = 1;
    localparam int CTRL_WIDE_BIT = 2;
    localparam int CTRL_HS_BIT = 3;
    localparam int ST_RX_BIT = 0;
    localparam int ST_DONE_BIT = 1;
    localparam int ST_WAKE_BIT = 2;
    localparam logic [15:0] DIV_RESET = 16'h0000;
    localparam logic [15:0] ABD_COUNT_START = 16'h0001;
    localparam logic [2:0] ABD_RISE_COUNT = 3'h5;
    localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
    // base divide by 4,16,64 is prescale 1,4,16 of a /4 tick
    localparam logic [3:0] PRE_FAST = 4'h0;
    localparam logic [3:0] PRE_MID = 4'h3;
    localparam logic [3:0] PRE_SLOW = 4'hf;
    localparam logic [1:0] SYS_PER_TICK = 2'h3;
    localparam logic [2:0] ABD_DIV8 = 3'h7;
    typedef enum logic [2:0] {
        UABD_IDLE = 3'b000,
        UABD_WAIT_START = 3'b001,
        UABD_WAIT_RISE = 3'b010,
        UABD_MEASURE = 3'b011,
        UABD_WAKE_LOW = 3'b100
    } uabd_state_t;
endpackage

// ===== inc/uabd_tick_if.sv
// interface carrying divider selection and ticks between modules
interface uabd_tick_if;
    logic wide;
    logic high_speed;
    logic base_tick;
    logic abd_tick;
    logic abd_sync;
    modport src(input wide, input high_speed, input abd_sync,
        output base_tick, output abd_tick);
    modport dst(output wide, output high_speed, output abd_sync,
        input base_tick, input abd_tick);
endinterface

// ===== core/uabd_clkgen.sv
// base and auto-baud counter clock enables
module uabd_clkgen (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    uabd_tick_if.src tk
);
    typedef struct packed {
        logic [1:0] q;
        logic [3:0] pre;
        logic [2:0] eighth;
        logic base;
        logic abd;
    } uabd_cg_t;
    uabd_cg_t r, next_r;
    logic [3:0] pre_top;
    always_comb
    begin
        case ({tk.wide, tk.high_speed})
            2'b00: pre_top = uabd_pkg::PRE_SLOW;
            2'b11: pre_top = uabd_pkg::PRE_FAST;
            default: pre_top = uabd_pkg::PRE_MID;
        endcase
        next_r = r;
        next_r.base = 1'b0;
        next_r.abd = 1'b0;
        next_r.q = r.q + 2'h1;
        if (r.q == uabd_pkg::SYS_PER_TICK)
        begin
            next_r.q = 2'h0;
            if (r.pre >= pre_top)
            begin
                next_r.pre = 4'h0;
                next_r.base = 1'b1;
                next_r.eighth = r.eighth + 3'h1;
                if (r.eighth == uabd_pkg::ABD_DIV8)
                    next_r.abd = 1'b1;
            end
            else
                next_r.pre = r.pre + 4'h1;
        end
        if (tk.abd_sync)
        begin
            // a base tick on the sync edge counts as the first eighth,
            // a measuring tick still pending from before sync is dropped
            next_r.eighth = {2'h0, next_r.base};
            next_r.abd = 1'b0;
        end
    end
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            r <= '0;
        else
            r <= next_r;
    end
    assign tk.base_tick = r.base;
    assign tk.abd_tick = r.abd;
endmodule

// ===== core/uabd_bitgen.sv
// normal-mode bit period generator from the divisor
module uabd_bitgen (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic run_i,
    input wire logic [15:0] divisor_i,
    input wire logic base_tick_i,
    output logic bit_tick_o
);
    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } uabd_bg_t;
    uabd_bg_t r, next_r;
    always_comb
    begin
        next_r = r;
        next_r.tick = 1'b0;
        if (!run_i)
            next_r.cnt = 16'h0000;
        else if (base_tick_i)
        begin
            if (r.cnt >= divisor_i)
            begin
                next_r.cnt = 16'h0000;
                next_r.tick = 1'b1;
            end
            else
                next_r.cnt = r.cnt + 16'h0001;
        end
    end
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            r <= '0;
        else
            r <= next_r;
    end
    assign bit_tick_o = r.tick;
endmodule

// ===== tb/uabd_assertions.sv
// port-level checker for the auto-baud detect unit
module uabd_assertions (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic rx_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic irq_o,
    input wire logic receiver_idle_o,
    input wire logic bit_tick_o
);
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (!rstn_i);
    sequence s_wr;
        avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
    endsequence
    sequence s_rd;
        avs_read_i && !avs_waitrequest_o;
    endsequence
    a_one_wait: assert property (
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("request not answered");
    a_abd_idle: assert property (
        s_wr ##0 (avs_address_i == uabd_pkg::ADDR_CTRL && avs_writedata_i[0])
        |-> ##[1:2] receiver_idle_o) else $error("receiver not held");
    a_no_tick_idle: assert property (
        receiver_idle_o && $past(receiver_idle_o) |-> !bit_tick_o)
        else $error("bit tick while held");
    a_tick_pulse: assert property (
        bit_tick_o |=> !bit_tick_o) else $error("long bit tick");
    a_unmapped_zero: assert property (
        s_rd ##0 avs_address_i > 4'h5 |-> avs_readdata_o == 32'h0)
        else $error("unmapped read not zero");
    a_div_byte: assert property (
        s_rd ##0 (avs_address_i == uabd_pkg::ADDR_DIV_LO
        || avs_address_i == uabd_pkg::ADDR_DIV_HI)
        |-> avs_readdata_o[31:8] == 24'h0) else $error("divisor byte wide");
    a_idle_on_rise: assert property (
        $fell(receiver_idle_o) && !$past(avs_write_i) |-> rx_i)
        else $error("hold ended without rise");
    a_irq_masked: assert property (
        s_wr ##0 (avs_address_i == uabd_pkg::ADDR_MASK
        && avs_writedata_i[2:0] == 3'h0) |=> !irq_o) else $error("irq masked");
endmodule
bind uabd_top uabd_assertions chk (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .rx_i(rx_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o),
    .receiver_idle_o(receiver_idle_o), .bit_tick_o(bit_tick_o));

// ===== tb/uabd_tx_model.sv
// remote serial transmitter driving the receive line
module uabd_tx_model (
    input wire logic sys_clk_i,
    output logic line_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial line_o = 1'h1;
    task automatic hold(input logic lvl, input int cyc);
        @(posedge sys_clk_i);
        line_o <= lvl;
        repeat (cyc - 1) @(posedge sys_clk_i);
    endtask
    // start bit, data lsb first, stop bit; line rests high
    task automatic send(input logic [7:0] data, input int cyc);
        hold(1'h0, cyc);
        for (int i = 0; i < 8; i++)
            hold(data[i], cyc);
        hold(1'h1, cyc);
    endtask
endmodule

// ===== tb/tb_uart_autobaud_detect.sv
// self-checking bench for the auto-baud detect unit
module tb_uart_autobaud_detect;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_i = 1'h0;
    logic rstn_i = 1'h0;
    logic rd = 1'h0;
    logic wr = 1'h0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] be = 4'hf;
    logic [31:0] rdata, got;
    logic wait_o, irq, idle, tick, rx;
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;
    int q[$];
    uabd_top dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .rx_i(rx),
        .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdata), .avs_byteenable_i(be),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
        .irq_o(irq), .receiver_idle_o(idle), .bit_tick_o(tick));
    uabd_tx_model tx (.sys_clk_i(sys_clk_i), .line_o(rx));
    initial
    begin
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) cyc <= cyc + 1;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [3:0] a,
        input logic [31:0] d);
        @(posedge sys_clk_i);
        addr <= a;
        wdata <= d;
        rd <= !w;
        wr <= w;
        // hold the request until waitrequest is seen low at a rising edge
        do
            @(posedge sys_clk_i);
        while (wait_o !== 1'h0);
        got = rdata;
        rd <= 1'h0;
        wr <= 1'h0;
    endtask
    task automatic tick_at(output int t);
        @(negedge sys_clk_i);
        while (tick !== 1'h1)
            @(negedge sys_clk_i);
        t = cyc;
    endtask
    task automatic detect(input logic [1:0] sel, input int bt,
        input logic wake, input logic [31:0] mask);
        int lo;
        q.push_back(1 + 8 * bt / (512 >> 2 * $countones(sel)));
        bus(1'h1, uabd_pkg::ADDR_MASK, mask);
        bus(1'h1, uabd_pkg::ADDR_CTRL, {28'h0, sel, wake, 1'h1});
        repeat (2) @(negedge sys_clk_i);
        check(idle, 1'h1);
        if (wake)
        begin
            tx.hold(1'h0, 11 * bt);
            tx.hold(1'h1, bt);
            bus(1'h0, uabd_pkg::ADDR_STATUS, 32'h0);
            check(got, 32'h5);
            bus(1'h0, uabd_pkg::ADDR_CTRL, 32'h0);
            check(got & 32'h3, 32'h1);
            bus(1'h1, uabd_pkg::ADDR_STATUS, 32'h7);
        end
        tx.send(8'h55, bt);
        bus(1'h0, uabd_pkg::ADDR_CTRL, 32'h0);
        check(got & 32'h1, 32'h0);
        bus(1'h0, uabd_pkg::ADDR_STATUS, 32'h0);
        check(got, 32'h3);
        @(negedge sys_clk_i);
        check(irq, |mask[1:0]);
        bus(1'h0, uabd_pkg::ADDR_RXDATA, 32'h0);
        bus(1'h0, uabd_pkg::ADDR_STATUS, 32'h0);
        check(got, 32'h2);
        bus(1'h1, uabd_pkg::ADDR_STATUS, 32'h2);
        @(negedge sys_clk_i);
        check(irq, 1'h0);
        bus(1'h0, uabd_pkg::ADDR_DIV_LO, 32'h0);
        lo = got;
        bus(1'h0, uabd_pkg::ADDR_DIV_HI, 32'h0);
        if (!sel[0])
            check(got, 32'h0);
        check(got << 8 | lo, q.pop_front());
    endtask
    initial
    begin
        int d, t1, t2;
        void'($urandom(32'h08f9));
        repeat (3) @(posedge sys_clk_i);
        rstn_i <= 1'h1;
        bus(1'h0, 4'hc, 32'h0);
        check(got, 32'h0);
        // a write without byte lane 0 is ignored
        be <= 4'he;
        bus(1'h1, uabd_pkg::ADDR_MASK, 32'h7);
        be <= 4'hf;
        bus(1'h0, uabd_pkg::ADDR_MASK, 32'h0);
        check(got, 32'h0);
        for (int m = 0; m < 4; m++)
        begin
            detect(m[1:0], 64 * (1 + $urandom % 4), m == 3, $urandom % 8);
            d = $urandom % 64;
            bus(1'h1, uabd_pkg::ADDR_DIV_LO, d);
            bus(1'h1, uabd_pkg::ADDR_DIV_HI, 32'h0);
            tick_at(t1);
            tick_at(t1);
            tick_at(t2);
            check(t2 - t1, (64 >> 2 * $countones(m[1:0])) * (d + 1));
        end
        detect(2'h3, 1088, 1'h0, 32'h0);
        test_done;
    end
    initial
    begin
        #900000;
        err_total++;
        test_done;
    end
endmodule
